// File: verilog/lsc_regs.svh
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
// lane count and field widths
`define LSC_LANES 8
`define LSC_CODE_W 4
`define LSC_SEL_W 2
`define LSC_EQV_W 8
// number of store/recall buffers
`define LSC_NBUF 3
// fixed input equalization: last dB code
`define LSC_TXEQ_MAX 4'hC
// emphasis: last dB code, first custom code
`define LSC_EMPH_MAX 4'h7
`define LSC_EMPH_CUST 4'hB
// amplitude: last range code, custom code
`define LSC_AMP_MAX 4'h3
`define LSC_AMP_CUST 4'hF
// module flag vector bit positions
`define LSC_MF_STATE 0
`define LSC_MF_TEMP 1
`define LSC_MF_VCC 2
`define LSC_MF_TEC_CUR 3
`define LSC_MF_TEC_TEMP 4
`define LSC_MF_LAS_TEMP2 5
`define LSC_MF_LAS_TEMP3 6
`define LSC_MF_AUX_VOLT 7
`define LSC_MF_VENDOR 8
`define LSC_MF_W 9
// lane flag vector bit positions
`define LSC_LF_PSC 0
`define LSC_LF_TXFAULT 1
`define LSC_LF_TXLOS 2
`define LSC_LF_TXLOL 3
`define LSC_LF_EQFAULT 4
`define LSC_LF_HI_AW 5
`define LSC_LF_LO_AW 6
`define LSC_LF_RXLOS 7
`define LSC_LF_RXLOL 8
`define LSC_LF_W 9
// flags allowed in any path state / only in path_active
`define LSC_LF_ANY_MASK 9'h0A3
`define LSC_LF_ACT_MASK 9'h14C
`endif

// File: verilog/lsc_pkg.sv
package lsc_pkg;
    // module state, coded as advertised
    typedef enum logic [2:0] {
        MOD_RESET = 3'h0,
        MOD_LOW_POWER = 3'h1,
        MOD_POWERING_UP = 3'h2,
        MOD_READY_A = 3'h3,
        MOD_POWERING_DOWN = 3'h4,
        MOD_FAULT = 3'h5,
        MOD_MGMT_SETUP = 3'h6
    } lsc_mod_t;
    // data path state, gray along off-start-active-stop
    typedef enum logic [1:0] {
        DP_OFF = 2'h0,
        DP_STARTING = 2'h1,
        DP_ACTIVE = 2'h3,
        DP_STOPPING = 2'h2
    } lsc_dp_t;
    // equalizer seeding action for one lane
    typedef enum logic [1:0] {
        EQ_ADAPT = 2'h0,
        EQ_FROZEN = 2'h1,
        EQ_FIXED = 2'h3
    } lsc_eqm_t;
endpackage

// File: verilog/lsc_lane_if.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
// per-lane state handed from the top to the flag gate
interface lsc_lane_if;
    lsc_pkg::lsc_mod_t mod_state; // module state
    lsc_pkg::lsc_dp_t dp_state [`LSC_LANES]; // path state per lane
    logic start_max_zero; // path_start_max_time encoding is zero
    logic stop_max_zero; // path_stop_max_time encoding is zero
    logic [`LSC_LF_W-1:0] lane_raw [`LSC_LANES]; // raw lane conditions
    logic [`LSC_LF_W-1:0] lane_ok [`LSC_LANES]; // gated lane set strobes
    modport top (output mod_state, dp_state, start_max_zero, stop_max_zero, lane_raw,
                 input lane_ok);
    modport gate (input mod_state, dp_state, start_max_zero, stop_max_zero, lane_raw,
                  output lane_ok);
endinterface

// File: verilog/lsc_lane_gate.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
// per-lane flag permission, evaluated in the detection cycle
module lsc_lane_gate (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    lsc_lane_if.gate lif
);
    lsc_pkg::lsc_dp_t prev_q [`LSC_LANES]; // path state one cycle ago

    // lanes silent while module is in reset or management setup
    function automatic logic mod_blocks(input lsc_pkg::lsc_mod_t m);
        mod_blocks = (m == lsc_pkg::MOD_RESET) || (m == lsc_pkg::MOD_MGMT_SETUP);
    endfunction

    // remember previous path state to see transitions
    always_ff @(posedge SYS_CLK) begin
        for (int i = 0; i < `LSC_LANES; i++) begin
            if (!RESETN) begin
                prev_q[i] <= lsc_pkg::DP_OFF;
            end else begin
                prev_q[i] <= lif.dp_state[i];
            end
        end
    end

    // mask raw conditions by current states, nothing latched for later
    always_comb begin
        for (int i = 0; i < `LSC_LANES; i++) begin
            logic [`LSC_LF_W-1:0] allow;
            logic psc_ok;
            psc_ok = 1'b0;
            allow = `LSC_LF_ANY_MASK;
            if (lif.dp_state[i] == lsc_pkg::DP_ACTIVE) begin
                allow = allow | `LSC_LF_ACT_MASK;
            end
            if (lif.dp_state[i] == lsc_pkg::DP_ACTIVE ||
                lif.dp_state[i] == lsc_pkg::DP_STARTING) begin
                allow[`LSC_LF_EQFAULT] = 1'b1;
            end
            // state change only on start->active or stop->off
            psc_ok = (prev_q[i] == lsc_pkg::DP_STARTING &&
                      lif.dp_state[i] == lsc_pkg::DP_ACTIVE && !lif.start_max_zero) ||
                     (prev_q[i] == lsc_pkg::DP_STOPPING &&
                      lif.dp_state[i] == lsc_pkg::DP_OFF && !lif.stop_max_zero);
            allow[`LSC_LF_PSC] = psc_ok;
            if (mod_blocks(lif.mod_state)) begin
                allow = '0;
            end
            lif.lane_ok[i] = lif.lane_raw[i] & allow;
        end
    end
endmodule

// File: verilog/lsc_top.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
module lsc_top (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // module and path states
    input wire lsc_pkg::lsc_mod_t MOD_STATE,
    input wire lsc_pkg::lsc_dp_t DP_STATE [`LSC_LANES],
    input wire logic [3:0] PATH_START_MAX_TIME,
    input wire logic [3:0] PATH_STOP_MAX_TIME,
    // vendor feature in low power
    input wire logic VENDOR_LOW_POWER_FEATURE,

    // per-lane controls from the active set
    input wire logic [`LSC_LANES-1:0] ADAPT_EN,
    input wire logic [`LSC_LANES-1:0] ADAPT_FREEZE,
    input wire logic [`LSC_CODE_W-1:0] TX_EQ_CODE [`LSC_LANES],
    input wire logic [`LSC_CODE_W-1:0] RX_EMPH_CODE [`LSC_LANES],
    input wire logic [`LSC_CODE_W-1:0] RX_AMP_CODE [`LSC_LANES],

    // store control write strobe and code
    input wire logic STORE_WR,
    input wire logic [`LSC_SEL_W-1:0] STORE_CODE [`LSC_LANES],

    // staged recall write, selecting staged set 0 or 1
    input wire logic RECALL_WR,
    input wire logic RECALL_SET,
    input wire logic [`LSC_SEL_W-1:0] RECALL_WDATA [`LSC_LANES],

    // apply controls for one staged set
    input wire logic APPLY_SET,
    input wire logic [`LSC_LANES-1:0] APPLY_WITH_REINIT,
    input wire logic [`LSC_LANES-1:0] APPLY_IMMEDIATE,

    // latest adapted equalizer value per lane
    input wire logic [`LSC_EQV_W-1:0] ADAPTED_EQ [`LSC_LANES],

    // raw flag conditions
    input wire logic [`LSC_MF_W-1:0] MOD_FLAG_RAW,
    input wire logic [`LSC_LF_W-1:0] LANE_FLAG_RAW [`LSC_LANES],

    // outputs
    output logic [`LSC_SEL_W-1:0] STORE_RDATA [`LSC_LANES],
    output logic [`LSC_SEL_W-1:0] STAGED_RECALL [2][`LSC_LANES],
    output logic [`LSC_SEL_W-1:0] ACTIVE_RECALL [`LSC_LANES],
    output logic [`LSC_LANES-1:0] REINIT_REQ,
    output logic [`LSC_LANES-1:0] LOAD_EQ,
    output logic [`LSC_EQV_W-1:0] LOAD_EQ_VALUE [`LSC_LANES],
    output lsc_pkg::lsc_eqm_t EQ_MODE [`LSC_LANES],
    output logic [`LSC_CODE_W-1:0] FIXED_EQ_DB [`LSC_LANES],
    output logic [`LSC_LANES-1:0] FIXED_EQ_CUSTOM,
    output logic [2:0] EMPH_POST_STEPS [`LSC_LANES],
    output logic [2:0] EMPH_PRE_HALF_STEPS [`LSC_LANES],
    output logic [`LSC_LANES-1:0] EMPH_CUSTOM,
    output logic [`LSC_LANES-1:0] EMPH_RESERVED,
    output logic [1:0] AMP_RANGE [`LSC_LANES],
    output logic [`LSC_LANES-1:0] AMP_CUSTOM,
    output logic [`LSC_LANES-1:0] AMP_RESERVED,
    output logic [`LSC_MF_W-1:0] MOD_FLAG_SET,
    output logic [`LSC_LF_W-1:0] LANE_FLAG_SET [`LSC_LANES]
);
    // store/recall buffers, one word per lane each
    logic [`LSC_EQV_W-1:0] buf_q [`LSC_NBUF][`LSC_LANES];
    logic [`LSC_SEL_W-1:0] staged_q [2][`LSC_LANES]; // staged recall codes
    logic [`LSC_SEL_W-1:0] active_q [`LSC_LANES]; // applied recall codes
    logic [`LSC_LANES-1:0] reinit_q; // reinit request pulse
    logic [`LSC_LANES-1:0] load_q; // equalizer load pulse
    logic [`LSC_EQV_W-1:0] loadv_q [`LSC_LANES]; // value to load
    lsc_pkg::lsc_mod_t mod_q; // module state, registered

    // states to the lane gate, gated flags back
    lsc_lane_if lif ();

    // code 0 means nothing to store or recall; else buffer index plus one
    function automatic logic sel_valid(input logic [`LSC_SEL_W-1:0] c);
        // beyond count: ignored
        sel_valid = (c != 2'h0) && ({30'h0, c} <= `LSC_NBUF);
    endfunction

    // buffer store on a store write, gated by adaptive enable
    // unpowered path: dropped
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < `LSC_LANES; l++) begin
            for (int b = 0; b < `LSC_NBUF; b++) begin
                if (!RESETN) begin
                    // buffers start empty
                    buf_q[b][l] <= 8'h00;
                end else if (STORE_WR && ADAPT_EN[l] &&
                             DP_STATE[l] != lsc_pkg::DP_OFF &&
                             sel_valid(STORE_CODE[l]) &&
                             STORE_CODE[l] == 2'(b + 1)) begin
                    // adapting goes on
                    buf_q[b][l] <= ADAPTED_EQ[l];
                end
            end
        end
    end

    // store control never reads back
    always_comb begin
        for (int l = 0; l < `LSC_LANES; l++) begin
            // write-only field
            STORE_RDATA[l] = 2'h0;
        end
    end

    // staged recall codes held per set and lane
    always_ff @(posedge SYS_CLK) begin
        for (int s = 0; s < 2; s++) begin
            for (int l = 0; l < `LSC_LANES; l++) begin
                if (!RESETN) begin
                    // no recall staged
                    staged_q[s][l] <= 2'h0;
                end else if (RECALL_WR && RECALL_SET == 1'(s)) begin
                    // all lanes written
                    staged_q[s][l] <= RECALL_WDATA[l];
                end
            end
        end
    end

    // apply copies staged code into active; reinit wins over immediate
    // no-buffer code: copy, no load
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < `LSC_LANES; l++) begin
            if (!RESETN) begin
                // nothing applied yet
                active_q[l] <= 2'h0;
                reinit_q[l] <= 1'b0;
                load_q[l] <= 1'b0;
                loadv_q[l] <= 8'h00;
            end else begin

                // pulses last one cycle
                reinit_q[l] <= APPLY_WITH_REINIT[l];
                load_q[l] <= 1'b0;

                if (APPLY_WITH_REINIT[l] || APPLY_IMMEDIATE[l]) begin
                    // explicit control bit plays no part
                    active_q[l] <= staged_q[APPLY_SET][l];
                    if (ADAPT_EN[l] && sel_valid(staged_q[APPLY_SET][l])) begin
                        // buffer k-1
                        load_q[l] <= 1'b1;
                        loadv_q[l] <= buf_q[2'(staged_q[APPLY_SET][l] - 2'h1)][l];
                    end
                end
            end
        end
    end

    // registered module state for flag gating
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            // blocks every flag
            mod_q <= lsc_pkg::MOD_RESET;
        end else begin
            // state at the last edge
            mod_q <= MOD_STATE;
        end
    end

    // equalizer mode and code decode per lane
    always_comb begin
        for (int l = 0; l < `LSC_LANES; l++) begin
            // adaptive on: adapt (seed or continue) unless frozen
            if (!ADAPT_EN[l]) begin
                // fixed code drives eq
                EQ_MODE[l] = lsc_pkg::EQ_FIXED;
            end else if (ADAPT_FREEZE[l]) begin
                // value held as is
                EQ_MODE[l] = lsc_pkg::EQ_FROZEN;
            end else begin
                // adapting, maybe seeded
                EQ_MODE[l] = lsc_pkg::EQ_ADAPT;
            end

            // fixed eq ignored while adaptive enabled
            FIXED_EQ_DB[l] = 4'h0;
            FIXED_EQ_CUSTOM[l] = 1'b0;
            if (!ADAPT_EN[l]) begin
                if (TX_EQ_CODE[l] <= `LSC_TXEQ_MAX) begin
                    // code is the dB value
                    FIXED_EQ_DB[l] = TX_EQ_CODE[l];
                end else begin
                    // codes 13-15
                    FIXED_EQ_CUSTOM[l] = 1'b1;
                end
            end

            // emphasis: post steps 1 dB, pre steps 0.5 dB
            EMPH_POST_STEPS[l] = 3'h0;
            EMPH_PRE_HALF_STEPS[l] = 3'h0;
            EMPH_CUSTOM[l] = RX_EMPH_CODE[l] >= `LSC_EMPH_CUST;
            EMPH_RESERVED[l] = RX_EMPH_CODE[l] > `LSC_EMPH_MAX &&
                               RX_EMPH_CODE[l] < `LSC_EMPH_CUST;
            if (RX_EMPH_CODE[l] <= `LSC_EMPH_MAX) begin
                // both cursors follow code
                EMPH_POST_STEPS[l] = RX_EMPH_CODE[l][2:0];
                EMPH_PRE_HALF_STEPS[l] = RX_EMPH_CODE[l][2:0];
            end

            // amplitude: four ranges, custom top code
            AMP_RANGE[l] = RX_AMP_CODE[l][1:0];
            AMP_CUSTOM[l] = RX_AMP_CODE[l] == `LSC_AMP_CUST;
            AMP_RESERVED[l] = RX_AMP_CODE[l] > `LSC_AMP_MAX &&
                              RX_AMP_CODE[l] != `LSC_AMP_CUST;
            if (RX_AMP_CODE[l] > `LSC_AMP_MAX) begin
                // reserved or custom
                AMP_RANGE[l] = 2'h0;
            end
        end
    end

    // module flag gating against registered module state
    // blocked: lost, not kept
    always_comb begin
        logic [`LSC_MF_W-1:0] allow;
        allow = '1;
        case (mod_q)
            lsc_pkg::MOD_LOW_POWER,
            lsc_pkg::MOD_FAULT: begin
                // aux tec, laser flags
                allow[`LSC_MF_TEC_CUR] = 1'b0;
                allow[`LSC_MF_TEC_TEMP] = 1'b0;
                allow[`LSC_MF_LAS_TEMP2] = 1'b0;
                allow[`LSC_MF_LAS_TEMP3] = 1'b0;
                if (mod_q == lsc_pkg::MOD_FAULT) begin
                    // kept in fault
                    allow[`LSC_MF_VENDOR] = 1'b1;
                end else begin
                    // only if feature stays
                    allow[`LSC_MF_VENDOR] = VENDOR_LOW_POWER_FEATURE;
                end
            end
            lsc_pkg::MOD_POWERING_UP,
            lsc_pkg::MOD_POWERING_DOWN,
            lsc_pkg::MOD_READY_A: begin
                // every flag allowed
                allow = '1;
            end
            default: begin
                // reset, setup, unknown
                allow = '0;
            end
        endcase

        // raw pulses pass or drop
        MOD_FLAG_SET = MOD_FLAG_RAW & allow;
    end

    // lane flag gate
    always_comb begin
        // registered module state
        lif.mod_state = mod_q;
        lif.start_max_zero = PATH_START_MAX_TIME == 4'h0;
        lif.stop_max_zero = PATH_STOP_MAX_TIME == 4'h0;
        for (int l = 0; l < `LSC_LANES; l++) begin
            lif.dp_state[l] = DP_STATE[l];
            lif.lane_raw[l] = LANE_FLAG_RAW[l];
            // gated flags out
            LANE_FLAG_SET[l] = lif.lane_ok[l];
        end
    end

    // per-lane permission
    lsc_lane_gate u_gate (
        .SYS_CLK(SYS_CLK),
        .RESETN(RESETN),
        .lif(lif)
    );

    // registers to ports
    assign STAGED_RECALL = staged_q;
    assign ACTIVE_RECALL = active_q;
    assign REINIT_REQ = reinit_q;
    assign LOAD_EQ = load_q;
    assign LOAD_EQ_VALUE = loadv_q;
endmodule

// File: verif/lsc_top_assertions.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
// watches the top ports for store, apply, mode and flag gating
module lsc_top_chk (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire lsc_pkg::lsc_mod_t MOD_STATE,
    input wire lsc_pkg::lsc_dp_t DP_STATE [`LSC_LANES],
    input wire logic [`LSC_LANES-1:0] ADAPT_EN,
    input wire logic [`LSC_LANES-1:0] ADAPT_FREEZE,
    input wire logic APPLY_SET,
    input wire logic [`LSC_LANES-1:0] APPLY_WITH_REINIT,
    input wire logic [`LSC_LANES-1:0] APPLY_IMMEDIATE,
    input wire logic [`LSC_MF_W-1:0] MOD_FLAG_RAW,
    input wire logic [`LSC_SEL_W-1:0] STORE_RDATA [`LSC_LANES],
    input wire logic [`LSC_SEL_W-1:0] STAGED_RECALL [2][`LSC_LANES],
    input wire logic [`LSC_SEL_W-1:0] ACTIVE_RECALL [`LSC_LANES],
    input wire logic [`LSC_LANES-1:0] REINIT_REQ,
    input wire lsc_pkg::lsc_eqm_t EQ_MODE [`LSC_LANES],
    input wire logic [`LSC_MF_W-1:0] MOD_FLAG_SET,
    input wire logic [`LSC_LF_W-1:0] LANE_FLAG_SET [`LSC_LANES]
);
    // single domain: one clock, one disable
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // store control never reads back a code
    property p_store_rd; STORE_RDATA[0] == 2'h0 && STORE_RDATA[7] == 2'h0; endproperty
    a_store_rd: assert property (p_store_rd) else $error("store readback not zero");
    // reinit request follows the reinit apply bits one cycle later
    property p_reinit; 1'b1 |=> REINIT_REQ == $past(APPLY_WITH_REINIT); endproperty
    a_reinit: assert property (p_reinit) else $error("reinit request wrong");
    // any apply copies the staged code of the chosen set
    property p_apply;
        (APPLY_IMMEDIATE[0] || APPLY_WITH_REINIT[0])
            |=> ACTIVE_RECALL[0] == $past(STAGED_RECALL[APPLY_SET][0]);
    endproperty
    a_apply: assert property (p_apply) else $error("active recall not copied");
    // without apply the active code holds
    property p_hold;
        !(APPLY_IMMEDIATE[0] || APPLY_WITH_REINIT[0]) |=> $stable(ACTIVE_RECALL[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("active recall moved alone");
    // fixed when adaptive off, frozen or adapting otherwise
    property p_mode;
        EQ_MODE[0] == (!ADAPT_EN[0] ? lsc_pkg::EQ_FIXED :
            (ADAPT_FREEZE[0] ? lsc_pkg::EQ_FROZEN : lsc_pkg::EQ_ADAPT));
    endproperty
    a_mode: assert property (p_mode) else $error("equalizer mode wrong");
    // no module flag in reset or setup
    property p_mod_off;
        $past(MOD_STATE) inside {lsc_pkg::MOD_RESET, lsc_pkg::MOD_MGMT_SETUP}
            |-> MOD_FLAG_SET == 9'h000;
    endproperty
    a_mod_off: assert property (p_mod_off) else $error("module flag in reset");
    // aux tec and laser flags blocked in low power and fault
    property p_mod_aux;
        $past(MOD_STATE) inside {lsc_pkg::MOD_LOW_POWER, lsc_pkg::MOD_FAULT}
            |-> MOD_FLAG_SET[6:3] == 4'h0;
    endproperty
    a_mod_aux: assert property (p_mod_aux) else $error("aux flag while blocked");
    // ready passes every module flag
    property p_mod_rdy;
        $past(RESETN) && $past(MOD_STATE) == lsc_pkg::MOD_READY_A |-> MOD_FLAG_SET == MOD_FLAG_RAW;
    endproperty
    a_mod_rdy: assert property (p_mod_rdy) else $error("ready flag dropped");
    // active-only lane flags stay low elsewhere
    property p_lane_act;
        DP_STATE[0] != lsc_pkg::DP_ACTIVE |-> (LANE_FLAG_SET[0] & `LSC_LF_ACT_MASK) == 9'h000;
    endproperty
    a_lane_act: assert property (p_lane_act) else $error("lane flag outside active");
    // state change flag only on a completing transition
    property p_psc;
        LANE_FLAG_SET[0][`LSC_LF_PSC] |-> $past(DP_STATE[0]) != DP_STATE[0]
            && DP_STATE[0] inside {lsc_pkg::DP_ACTIVE, lsc_pkg::DP_OFF};
    endproperty
    a_psc: assert property (p_psc) else $error("state change flag misplaced");
endmodule
bind lsc_top lsc_top_chk chk_u (.SYS_CLK, .RESETN, .MOD_STATE, .DP_STATE, .ADAPT_EN,
    .ADAPT_FREEZE, .APPLY_SET, .APPLY_WITH_REINIT, .APPLY_IMMEDIATE, .MOD_FLAG_RAW,
    .STORE_RDATA, .STAGED_RECALL, .ACTIVE_RECALL, .REINIT_REQ, .EQ_MODE, .MOD_FLAG_SET,
    .LANE_FLAG_SET);

// File: verif/lsc_host.sv
`timescale 1ns/1ps
// management host: one-cycle write strobes for store, recall and apply
module lsc_host (
    input wire logic clk,
    output logic store_wr,
    output logic [1:0] store_code [8],
    output logic recall_wr,
    output logic recall_set,
    output logic [1:0] recall_wdata [8],
    output logic apply_set,
    output logic [7:0] apply_reinit,
    output logic [7:0] apply_imm
);
    // bus quiet from time zero
    initial begin
        store_wr = 1'b0;
        recall_wr = 1'b0;
        recall_set = 1'b0;
        apply_set = 1'b0;
        apply_reinit = 8'h00;
        apply_imm = 8'h00;
        store_code = '{default: 2'h0};
        recall_wdata = '{default: 2'h0};
    end
    // store code c into lanes of mask m
    task automatic store(input logic [7:0] m, input logic [1:0] c);
        @(posedge clk);
        foreach (store_code[i]) store_code[i] <= m[i] ? c : 2'h0;
        store_wr <= 1'b1;
        @(posedge clk);
        store_wr <= 1'b0;
    endtask
    // write recall code c for lanes of mask m into staged set s
    task automatic recall(input logic s, input logic [7:0] m, input logic [1:0] c);
        @(posedge clk);
        foreach (recall_wdata[i]) recall_wdata[i] <= m[i] ? c : 2'h0;
        recall_set <= s;
        recall_wr <= 1'b1;
        @(posedge clk);
        recall_wr <= 1'b0;
    endtask
    // apply staged set s with reinit and immediate lane bits
    task automatic apply(input logic s, input logic [7:0] r, input logic [7:0] im);
        @(posedge clk);
        apply_set <= s;
        apply_reinit <= r;
        apply_imm <= im;
        @(posedge clk);
        apply_reinit <= 8'h00;
        apply_imm <= 8'h00;
    endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
    // clock, reset and tallies
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    int errors = 0;
    int checks = 0;
    // design inputs
    lsc_pkg::lsc_mod_t mod_state = lsc_pkg::MOD_RESET;
    lsc_pkg::lsc_dp_t dp_state [8] = '{default: lsc_pkg::DP_ACTIVE};
    logic [3:0] start_max = 4'h5;
    logic [3:0] stop_max = 4'h5;
    logic vend_lp = 1'b0;
    logic [7:0] adapt_en = 8'h00;
    logic [7:0] freeze = 8'h00;
    logic [3:0] txeq [8] = '{default: 4'h0};
    logic [3:0] emph [8] = '{default: 4'h0};
    logic [3:0] amp [8] = '{default: 4'h0};
    logic [7:0] adapted [8] = '{default: 8'h00};
    logic [8:0] mod_raw = 9'h000;
    logic [8:0] lane_raw [8] = '{default: 9'h000};
    logic store_wr, recall_wr, recall_set, apply_set;
    logic [1:0] store_code [8];
    logic [1:0] recall_wdata [8];
    logic [7:0] apply_reinit, apply_imm;
    // design outputs
    logic [1:0] store_rdata [8];
    logic [1:0] staged [2][8];
    logic [1:0] active [8];
    logic [7:0] reinit_req, load_eq, fix_cust, emph_cust, emph_res, amp_cust, amp_res;
    logic [7:0] load_val [8];
    lsc_pkg::lsc_eqm_t eq_mode [8];
    logic [3:0] fix_db [8];
    logic [2:0] post [8];
    logic [2:0] pre [8];
    logic [1:0] amp_rng [8];
    logic [8:0] mod_set;
    logic [8:0] lane_set [8];
    // 100 ns clock
    always #50 sys_clk = ~sys_clk;
    lsc_top dut_u (.SYS_CLK(sys_clk), .RESETN(resetn), .MOD_STATE(mod_state),
        .DP_STATE(dp_state), .PATH_START_MAX_TIME(start_max), .PATH_STOP_MAX_TIME(stop_max),
        .VENDOR_LOW_POWER_FEATURE(vend_lp), .ADAPT_EN(adapt_en), .ADAPT_FREEZE(freeze),
        .TX_EQ_CODE(txeq), .RX_EMPH_CODE(emph), .RX_AMP_CODE(amp), .STORE_WR(store_wr),
        .STORE_CODE(store_code), .RECALL_WR(recall_wr), .RECALL_SET(recall_set),
        .RECALL_WDATA(recall_wdata), .APPLY_SET(apply_set), .APPLY_WITH_REINIT(apply_reinit),
        .APPLY_IMMEDIATE(apply_imm), .ADAPTED_EQ(adapted), .MOD_FLAG_RAW(mod_raw),
        .LANE_FLAG_RAW(lane_raw), .STORE_RDATA(store_rdata), .STAGED_RECALL(staged),
        .ACTIVE_RECALL(active), .REINIT_REQ(reinit_req), .LOAD_EQ(load_eq),
        .LOAD_EQ_VALUE(load_val), .EQ_MODE(eq_mode), .FIXED_EQ_DB(fix_db),
        .FIXED_EQ_CUSTOM(fix_cust), .EMPH_POST_STEPS(post), .EMPH_PRE_HALF_STEPS(pre),
        .EMPH_CUSTOM(emph_cust), .EMPH_RESERVED(emph_res), .AMP_RANGE(amp_rng),
        .AMP_CUSTOM(amp_cust), .AMP_RESERVED(amp_res), .MOD_FLAG_SET(mod_set),
        .LANE_FLAG_SET(lane_set));
    lsc_host host_u (.clk(sys_clk), .store_wr(store_wr), .store_code(store_code),
        .recall_wr(recall_wr), .recall_set(recall_set), .recall_wdata(recall_wdata),
        .apply_set(apply_set), .apply_reinit(apply_reinit), .apply_imm(apply_imm));
    // compare and tally
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // every code of the three decodes, then the three eq modes
    task automatic t_decode();
        for (int c = 0; c < 16; c++) begin
            @(posedge sys_clk);
            txeq[0] <= 4'(c);
            emph[0] <= 4'(c);
            amp[0] <= 4'(c);
            @(negedge sys_clk);
            chk(9'(fix_cust[0]), 9'(c > 12));
            if (c <= 12) chk(9'(fix_db[0]), 9'(c));
            chk(9'({emph_cust[0], emph_res[0]}), c > 10 ? 9'h2 : 9'(c > 7));
            if (c < 8) chk(9'({post[0], pre[0]}), 9'({3'(c), 3'(c)}));
            chk(9'({amp_cust[0], amp_res[0]}), c == 15 ? 9'h2 : 9'(c > 3));
            if (c < 4) chk(9'(amp_rng[0]), 9'(c));
        end
        for (int i = 1; i < 4; i++) begin
            @(posedge sys_clk);
            adapt_en[0] <= i[1];
            freeze[0] <= i[0];
            @(negedge sys_clk);
            chk(9'(eq_mode[0]), i == 2 ? 9'h0 : (i == 3 ? 9'h1 : 9'h3));
        end
        $display("decode test done");
    endtask
    // module flags in every module state
    task automatic t_mod();
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            mod_state <= lsc_pkg::lsc_mod_t'(i == 7 ? 1 : i);
            vend_lp <= (i == 7);
            mod_raw <= 9'h1FF;
            @(posedge sys_clk);
            @(negedge sys_clk);
            case (i)
                0, 6: chk(mod_set, 9'h000);
                1: chk(mod_set, 9'h087);
                5: chk(mod_set, 9'h187);
                7: chk(mod_set, 9'h187);
                default: chk(mod_set, 9'h1FF);
            endcase
        end
        @(posedge sys_clk);
        mod_state <= lsc_pkg::MOD_READY_A;
        mod_raw <= 9'h000;
        $display("module flag test done");
    endtask
    // store, refused store, recall and apply immediate
    task automatic t_store();
        @(posedge sys_clk);
        adapt_en <= 8'h01;
        freeze <= 8'h00;
        adapted[0] <= 8'h5A;
        adapted[1] <= 8'h77;
        host_u.store(8'h03, 2'h2);
        @(negedge sys_clk);
        chk(9'(store_rdata[0]), 9'h000);
        @(posedge sys_clk);
        adapted[0] <= 8'hC3;
        host_u.recall(1'b0, 8'h03, 2'h2);
        @(negedge sys_clk);
        chk(9'({staged[0][0], active[0]}), 9'h008);
        @(posedge sys_clk);
        adapt_en <= 8'h03;
        host_u.apply(1'b0, 8'h00, 8'h03);
        @(negedge sys_clk);
        chk(9'({active[0], active[1], load_eq[1:0]}), 9'h02B);
        chk(9'(load_val[0]), 9'h05A);
        chk(9'(load_val[1]), 9'h000);
        chk(9'(reinit_req), 9'h000);
        @(negedge sys_clk);
        chk(9'(load_eq), 9'h000);
        host_u.recall(1'b1, 8'h04, 2'h1);
        host_u.apply(1'b1, 8'h04, 8'h04);
        @(negedge sys_clk);
        chk(9'({reinit_req, active[2] == 2'h1}), 9'h009);
        chk(9'(load_eq), 9'h000);
        $display("store recall test done");
    endtask
    // lane flags along the path cycle, with and without max time
    task automatic t_lane();
        lsc_pkg::lsc_dp_t sq [4];
        logic [8:0] e;
        sq = '{lsc_pkg::DP_STARTING, lsc_pkg::DP_ACTIVE, lsc_pkg::DP_STOPPING, lsc_pkg::DP_OFF};
        @(posedge sys_clk);
        dp_state[0] <= lsc_pkg::DP_OFF;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge sys_clk);
                dp_state[0] <= sq[k];
                lane_raw[0] <= 9'h1FF;
                start_max <= p ? 4'h0 : 4'h5;
                stop_max <= p ? 4'h0 : 4'h5;
                e = k == 1 ? 9'h1FE : (k == 0 ? 9'h0B2 : 9'h0A2);
                @(negedge sys_clk);
                chk(lane_set[0], e | 9'((k % 2) && !p));
                @(negedge sys_clk);
                chk(lane_set[0], e);
            end
        end
        @(posedge sys_clk);
        mod_state <= lsc_pkg::MOD_MGMT_SETUP;
        mod_raw <= 9'h1FF;
        repeat (2) @(negedge sys_clk);
        chk(lane_set[0], 9'h000);
        chk(mod_set, 9'h000);
        $display("lane flag test done");
    endtask
    // verdict and stop
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        t_decode();
        t_mod();
        t_store();
        t_lane();
        end_sim();
    end
    // watchdog, far beyond the roughly 85 cycles needed
    initial begin
        #500000;
        errors++;
        end_sim();
    end
endmodule
